// ### test/sid_datapath_tb.sv
// Self-checking testbench of the subtract-instruction datapath
`timescale 1ns/10ps

module sid_datapath_tb;
   import sid_pkg::*;
   logic       clk_sys     = 1'b0;
   logic       rstn        = 1'b0;
   logic       opValid     = 1'b0;
   sid_op_e    opSel       = SID_OP_NONE;
   logic [7:0] memRdData   = 8'h00;
   logic [7:0] immData     = 8'h00;
   logic       accLoad     = 1'b0;
   logic [7:0] accLoadData = 8'h00;
   logic [7:0] accumulatorReg;
   logic [7:0] memWrData;
   logic       memWrEn, overflowFlag, zeroFlag, auxCarryFlag, carryFlag, opDone;
   int         num_errors  = 0;
   int         n_compared  = 0;
   int         cycleCount  = 0;

   sid_datapath sid_datapath_i (.clk_sys(clk_sys), .rstn(rstn), .opValid(opValid), .opSel(opSel),
      .memRdData(memRdData), .immData(immData), .accLoad(accLoad), .accLoadData(accLoadData),
      .accumulatorReg(accumulatorReg), .memWrData(memWrData), .memWrEn(memWrEn),
      .overflowFlag(overflowFlag), .zeroFlag(zeroFlag), .auxCarryFlag(auxCarryFlag),
      .carryFlag(carryFlag), .opDone(opDone));

   ////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycleCount++;
      if (cycleCount == 500) begin
         num_errors++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Comparison, verdict and drivers (entered at a falling edge, except the hang-guard verdict at a rising edge)
   task automatic check(string what, logic [7:0] seen, logic [7:0] expected);
      n_compared++;
      if (seen !== expected) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, expected, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic load_acc(logic [7:0] v);
      accLoad = 1'b1;
      accLoadData = v;
      @(negedge clk_sys);
      accLoad = 1'b0;
   endtask
   task automatic idle();
      opValid = 1'b0;
      opSel = SID_OP_NONE;
      @(negedge clk_sys);
      check("idleDone", opDone, 1'b0);
      check("idleWr", memWrEn, 1'b0);
   endtask
   // One subtract with accumulator a and operand b; judged one cycle later
   task automatic run_op(sid_op_e op, logic [7:0] a, logic [7:0] b);
      logic [7:0] d;
      d = a - b;
      opValid = 1'b1;
      opSel = op;
      memRdData = (op == SID_OP_SUB_IMM) ? ~b : b;
      immData = (op == SID_OP_SUB_IMM) ? b : ~b;
      @(negedge clk_sys);
      check("opDone", opDone, 1'b1);
      check("memWrEn", memWrEn, op == SID_OP_SUB_TO_MEMORY);
      check("acc", accumulatorReg, (op == SID_OP_SUB_TO_MEMORY) ? a : d);
      if (op == SID_OP_SUB_TO_MEMORY) check("memWrData", memWrData, d);
      check("carry", carryFlag, a >= b);
      check("zero", zeroFlag, d == 8'h00);
      check("aux", auxCarryFlag, a[3:0] >= b[3:0]);
      check("ovf", overflowFlag, (a[7] != b[7]) && (d[7] != a[7]));
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_memory_ops();
      logic [7:0] pa[6] = '{8'h50, 8'h30, 8'h80, 8'h22, 8'h10, 8'h7F};
      logic [7:0] pb[6] = '{8'h30, 8'h50, 8'h01, 8'h22, 8'h01, 8'hFF};
      for (int i = 0; i < 6; i++) begin
         load_acc(pa[i]);
         run_op(SID_OP_SUB_MEM, pa[i], pb[i]);
         idle();
         load_acc(pa[i]);
         run_op(SID_OP_SUB_TO_MEMORY, pa[i], pb[i]);
         idle();
      end
   endtask
   task automatic t_back_to_back();
      load_acc(8'h40);
      run_op(SID_OP_SUB_IMM, 8'h40, 8'h10);
      run_op(SID_OP_SUB_IMM, 8'h30, 8'h30);
      run_op(SID_OP_SUB_TO_MEMORY, 8'h00, 8'h01);
      run_op(SID_OP_SUB_MEM, 8'h00, 8'h80);
      opSel = SID_OP_NONE;
      @(negedge clk_sys);
      check("noneDone", opDone, 1'b0);
      check("noneWr", memWrEn, 1'b0);
      check("noneWrData", memWrData, 8'hFF);
      check("noneAcc", accumulatorReg, 8'h80);
      check("noneFlags", {overflowFlag, zeroFlag, auxCarryFlag, carryFlag}, 4'hA);
      idle();
   endtask

   // Subtracts into the accumulator override a load in the same cycle
   task automatic t_load_clash();
      accLoad = 1'b1;
      accLoadData = 8'h20;
      @(negedge clk_sys);
      accLoadData = 8'hAA;
      run_op(SID_OP_SUB_MEM, 8'h20, 8'h05);
      run_op(SID_OP_SUB_IMM, 8'h1B, 8'h1B);
      accLoad = 1'b0;
      idle();
   endtask

   initial begin
      repeat (5) @(negedge clk_sys);
      check("rstAcc", accumulatorReg, SID_ACCUM_RST);
      check("rstOut", {memWrEn, opDone, carryFlag, zeroFlag, overflowFlag, auxCarryFlag}, 6'h00);
      check("rstWrData", memWrData, SID_ACCUM_RST);
      rstn = 1'b1;
      @(negedge clk_sys);
      t_memory_ops();
      t_back_to_back();
      t_load_clash();
      report_and_stop();
   end
endmodule

// ### verilog/sid_datapath.sv
// Subtract-instruction datapath: accumulator, memory write-back and flags
// Notes on behaviour
// - Memory-operand subtract: accumulator minus memory byte into accumulator, four flags updated.
// - Subtract-to-memory: same difference written back to the memory location, same flags.
// - Immediate subtract: accumulator minus instruction constant into accumulator.
// - A borrow (negative result) clears the carry flag to 0.
// - No borrow (zero or positive result) sets the carry flag to 1.

`timescale 1ns/10ps

module sid_datapath (
   input  wire logic                          clk_sys,
   input  wire logic                          rstn,
   input  wire logic                          opValid,
   input  wire sid_pkg::sid_op_e              opSel,
   input  wire logic [sid_pkg::SID_DATA_W-1:0] memRdData,
   input  wire logic [sid_pkg::SID_DATA_W-1:0] immData,
   input  wire logic                          accLoad,
   input  wire logic [sid_pkg::SID_DATA_W-1:0] accLoadData,
   output logic      [sid_pkg::SID_DATA_W-1:0] accumulatorReg,
   output logic      [sid_pkg::SID_DATA_W-1:0] memWrData,
   output logic                               memWrEn,
   output logic                               overflowFlag,
   output logic                               zeroFlag,
   output logic                               auxCarryFlag,
   output logic                               carryFlag,
   output logic                               opDone
);
   import sid_pkg::*;

   logic [SID_DATA_W-1:0] operand;
   logic [SID_DATA_W-1:0] diff;
   logic                  noBorrow;
   logic                  nibbleNoBorrow;
   logic                  signedOverflow;
   logic                  isZero;
   logic                  doSub;
   logic                  toAccum;
   logic                  toMemory;
   logic [SID_DATA_W-1:0] accum_nxt;
   logic [SID_DATA_W-1:0] expDiff;

   ////////////////////////////////////////////////////////////////////////////
   // Operation decode and operand select
   assign doSub    = opValid & (opSel != SID_OP_NONE);
   assign toMemory = opValid & (opSel == SID_OP_SUB_TO_MEMORY);
   assign toAccum  = opValid & ((opSel == SID_OP_SUB_MEM) | (opSel == SID_OP_SUB_IMM));
   assign operand  = (opSel == SID_OP_SUB_IMM) ? immData : memRdData;

   // Shared subtract unit
   sid_subtractor #(
      .DataW   (SID_DATA_W),
      .NibbleW (SID_NIBBLE_W)
   ) u_sub (
      .minuend        (accumulatorReg),
      .subtrahend     (operand),
      .difference     (diff),
      .noBorrow       (noBorrow),
      .nibbleNoBorrow (nibbleNoBorrow),
      .signedOverflow (signedOverflow),
      .isZero         (isZero)
   );

   // Memory-operand or immediate subtract result beats a plain load in the same cycle
   assign accum_nxt = toAccum ? diff : (accLoad ? accLoadData : accumulatorReg);

   ////////////////////////////////////////////////////////////////////////////
   // Accumulator register
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         accumulatorReg <= SID_ACCUM_RST;
      end else begin
         accumulatorReg <= accum_nxt;
      end
   end

   // Memory write-back port, write enable is high for one cycle per subtract-to-memory
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         memWrData <= SID_ACCUM_RST;
         memWrEn   <= 1'b0;
         opDone    <= 1'b0;
      end else begin
         memWrData <= toMemory ? diff : memWrData;
         memWrEn   <= toMemory;
         opDone    <= doSub;
      end
   end

   // Status flags, updated by every subtract
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         overflowFlag <= SID_FLAG_RST;
         zeroFlag     <= SID_FLAG_RST;
         auxCarryFlag <= SID_FLAG_RST;
         carryFlag    <= SID_FLAG_RST;
      end else if (doSub) begin
         overflowFlag <= signedOverflow;
         zeroFlag     <= isZero;
         auxCarryFlag <= nibbleNoBorrow;
         carryFlag    <= noBorrow ? SID_NO_BORROW : SID_BORROW;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reference difference for the checks, independent of the subtract unit
   assign expDiff = accumulatorReg - operand;

   // Memory-operand subtract lands in the accumulator, no memory write
   a_acc_mem_sub: assert property (@(posedge clk_sys) disable iff (!rstn)
      (opValid && opSel == SID_OP_SUB_MEM) |=> (accumulatorReg == $past(expDiff)) && !memWrEn && opDone)
      else $error("memory subtract did not load accumulator");

   // Subtract-to-memory writes the difference back and leaves accumulator alone
   a_mem_write_back: assert property (@(posedge clk_sys) disable iff (!rstn)
      (opValid && opSel == SID_OP_SUB_TO_MEMORY && !accLoad)
      |=> memWrEn && (memWrData == $past(expDiff)) && $stable(accumulatorReg) ##1 !memWrEn || $past(toMemory))
      else $error("memory write-back wrong");

   // Immediate subtract uses the instruction constant
   a_imm_sub: assert property (@(posedge clk_sys) disable iff (!rstn)
      (opValid && opSel == SID_OP_SUB_IMM) |=> accumulatorReg == $past(accumulatorReg) - $past(immData))
      else $error("immediate subtract wrong");

   // Borrow clears the carry flag
   a_borrow_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
      (doSub && (accumulatorReg < operand)) |=> (carryFlag == 1'b0))
      else $error("carry not cleared on borrow");

   // No borrow sets the carry flag
   a_noborrow_set: assert property (@(posedge clk_sys) disable iff (!rstn)
      (doSub && (accumulatorReg >= operand)) |=> (carryFlag == 1'b1))
      else $error("carry not set without borrow");

   // Zero flag follows a zero difference
   a_zero_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
      doSub |=> zeroFlag == ($past(accumulatorReg) == $past(operand)))
      else $error("zero flag wrong");

   // Aux carry follows low-nibble no-borrow
   a_aux_carry: assert property (@(posedge clk_sys) disable iff (!rstn)
      doSub |=> auxCarryFlag == ($past(accumulatorReg[3:0]) >= $past(operand[3:0])))
      else $error("aux carry flag wrong");

   // Overflow when operand signs differ and result sign flips from minuend
   a_overflow_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
      doSub |=> overflowFlag == (($past(accumulatorReg[7]) != $past(operand[7]))
                                 && ($past(expDiff[7]) != $past(accumulatorReg[7]))))
      else $error("overflow flag wrong");

   // Flags hold when no subtract runs
   a_flags_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
      !doSub |=> $stable({overflowFlag, zeroFlag, auxCarryFlag, carryFlag}))
      else $error("flags changed without subtract");

   ////////////////////////////////////////////////////////////////////////////
   // Pulse, hold, priority, flag-consistency and reset checks on the outputs
   // Completion pulse only follows an accepted subtract
   a_done_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
      !doSub
      |=> !opDone)
      else $error("completion pulse without subtract");

   // Every accepted subtract reports completion on the next edge
   a_done_follows: assert property (@(posedge clk_sys) disable iff (!rstn)
      doSub
      |=> opDone)
      else $error("subtract without completion pulse");

   // Write strobe only follows a subtract-to-memory
   a_write_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
      !toMemory
      |=> !memWrEn)
      else $error("write strobe without write-back");

   // Write-back data holds between write-backs
   a_write_data_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
      !toMemory
      |=> $stable(memWrData))
      else $error("write-back data changed without write");

   // A write strobe is always part of a completed subtract
   a_write_with_done: assert property (@(posedge clk_sys) disable iff (!rstn)
      memWrEn
      |-> opDone)
      else $error("write strobe without completion");

   // A valid slot with no operation changes nothing
   a_none_ignored: assert property (@(posedge clk_sys) disable iff (!rstn)
      (opValid && opSel == SID_OP_NONE && !accLoad)
      |=> $stable(accumulatorReg) && !opDone && !memWrEn)
      else $error("empty operation had an effect");

   // Plain load reaches the accumulator when no subtract targets it
   a_acc_load: assert property (@(posedge clk_sys) disable iff (!rstn)
      (accLoad && !toAccum)
      |=> accumulatorReg == $past(accLoadData))
      else $error("accumulator load lost");

   // Accumulator holds without a load or an accumulator subtract
   a_acc_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
      (!accLoad && !toAccum)
      |=> $stable(accumulatorReg))
      else $error("accumulator changed without cause");

   // Memory-operand subtract wins over a load in the same cycle
   a_sub_over_load: assert property (@(posedge clk_sys) disable iff (!rstn)
      (accLoad && opValid && opSel == SID_OP_SUB_MEM)
      |=> accumulatorReg == $past(accumulatorReg) - $past(memRdData))
      else $error("load beat memory subtract");

   // A zero difference never borrows and never overflows
   a_zero_consistent: assert property (@(posedge clk_sys) disable iff (!rstn)
      (opDone && zeroFlag)
      |-> carryFlag && auxCarryFlag && !overflowFlag)
      else $error("zero result with inconsistent flags");

   // Asynchronous reset clears the accumulator, pulses and flags
   a_reset_clear: assert property (@(posedge clk_sys)
      !rstn ##1 !rstn
      |-> (accumulatorReg == SID_ACCUM_RST) && !memWrEn && !opDone
          && !overflowFlag && !zeroFlag && !auxCarryFlag && !carryFlag)
      else $error("outputs not cleared in reset");
endmodule

// ### verilog/sid_subtractor.sv
// Package of datapath constants and the 8-bit subtract-with-flags unit
`timescale 1ns/10ps

package sid_pkg;
   localparam int   SID_DATA_W   = 8;
   localparam int   SID_NIBBLE_W = 4;
   localparam int   SID_SIGN_BIT = SID_DATA_W - 1;
   localparam logic [7:0] SID_ACCUM_RST = 8'h00;
   localparam logic SID_FLAG_RST = 1'b0;
   localparam logic SID_NO_BORROW = 1'b1;
   localparam logic SID_BORROW    = 1'b0;

   // Operation selector from the instruction decoder
   typedef enum logic [1:0] {
      SID_OP_NONE    = 2'b00,
      SID_OP_SUB_MEM = 2'b01,
      SID_OP_SUB_TO_MEMORY = 2'b10,
      SID_OP_SUB_IMM = 2'b11
   } sid_op_e;
endpackage

////////////////////////////////////////////////////////////////////////////////
// Minuend minus subtrahend, with borrow-style carry, aux carry, overflow, zero
module sid_subtractor #(
   parameter int DataW   = sid_pkg::SID_DATA_W,
   parameter int NibbleW = sid_pkg::SID_NIBBLE_W
) (
   input  wire logic [DataW-1:0] minuend,
   input  wire logic [DataW-1:0] subtrahend,
   output logic      [DataW-1:0] difference,
   output logic                  noBorrow,
   output logic                  nibbleNoBorrow,
   output logic                  signedOverflow,
   output logic                  isZero
);
   import sid_pkg::*;

   logic [DataW:0]   wideDiff;
   logic [NibbleW:0] nibbleDiff;

   // Full-width and low-nibble differences, top bit is the borrow
   assign wideDiff   = {1'b0, minuend} - {1'b0, subtrahend};
   assign nibbleDiff = {1'b0, minuend[NibbleW-1:0]} - {1'b0, subtrahend[NibbleW-1:0]};
   assign difference = wideDiff[DataW-1:0];

   // Carry is inverted borrow: set when no borrow
   assign noBorrow       = ~wideDiff[DataW];
   assign nibbleNoBorrow = ~nibbleDiff[NibbleW];
   // Signs differ and result sign differs from minuend
   assign signedOverflow = (minuend[DataW-1] ^ subtrahend[DataW-1])
                         & (minuend[DataW-1] ^ wideDiff[DataW-1]);
   assign isZero = (wideDiff[DataW-1:0] == '0);
endmodule
